// ---- jfp_port.v ----
// Test-port flash programming front end: oversampled TAP controller, the
// instruction register and the reset, key, command and byte data registers.
// Assumes clk is much faster than tck; tck, tms, tdi and the external reset
// pin are asynchronous and are synchronised here. Flash and page buffer are
// outside; they take the pulses below and answer on the same clock.
`timescale 1ns/100ps
`include "jfp_consts.vh"
module jfp_port
(
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  tck,
  input  wire                  tms,
  input  wire                  tdi,
  output wire                  tdo,
  output wire                  tdo_oe,
  input  wire                  ext_reset_n,
  input  wire                  test_port_enable_fuse,
  input  wire [`JFP_CNT_W-1:0] timeout_cycles,
  input  wire                  disable_wr,
  input  wire                  disable_wdata,
  output wire                  test_port_disable_bit,
  output wire                  chip_reset,
  output wire                  prog_mode,
  output wire [`JFP_CMD_W-1:0] flash_cmd,
  output wire                  flash_cmd_load,
  output wire                  flash_exec,
  input  wire [`JFP_CMD_W-1:0] flash_result,
  output wire                  pbuf_wr,
  output wire                  pbuf_hi,
  output wire [7:0]            pbuf_data,
  output wire                  pc_inc,
  input  wire [15:0]           flash_word
);

  wire [3:0] pin_s;
  wire       tck_s;
  wire       tms_s;
  wire       tdi_s;
  wire       ext_reset_n_s;
  wire       port_on;
  wire       tck_rise;
  wire       tck_fall;

  reg                  tck_d_reg;
  reg [3:0]            state_reg;
  reg [3:0]            state_next;
  reg [`JFP_IR_W-1:0]  ir_reg;
  reg [`JFP_IR_W-1:0]  ir_sr_reg;
  reg                  rst_chain_reg;
  reg                  bypass_reg;
  reg [`JFP_KEY_W-1:0] key_sr_reg;
  reg [`JFP_CMD_W-1:0] cmd_sr_reg;
  reg                  unlocked_reg;
  reg [`JFP_CMD_W-1:0] flash_cmd_reg;
  reg                  flash_cmd_load_reg;
  reg                  flash_exec_reg;
  reg [7:0]            hold_reg;
  reg                  hold_pend_reg;
  reg                  load_hi_reg;
  reg                  load_first_reg;
  reg                  read_hi_reg;
  reg                  pbuf_wr_reg;
  reg                  pbuf_hi_reg;
  reg [7:0]            pbuf_data_reg;
  reg                  pc_inc_reg;
  reg                  tdo_reg;

  // Opcode test shared by capture, shift and update decoding
  function is_op;
    input [`JFP_IR_W-1:0] ir;
    input [`JFP_IR_W-1:0] op;
    begin
      is_op = (ir == op);
    end
  endfunction

  // All pins pass two flip-flops before any logic looks at them
  jfp_sync #(.W(4)) u_sync
  (
    .clk (clk),
    .rst (rst),
    .d   ({ext_reset_n, tdi, tms, tck}),
    .q   (pin_s)
  );

  assign tck_s         = pin_s[0];
  assign tms_s         = pin_s[1];
  assign tdi_s         = pin_s[2];
  assign ext_reset_n_s = pin_s[3];

  jfp_rst_ctl u_rst_ctl
  (
    .clk                   (clk),
    .rst                   (rst),
    .reset_chain           (rst_chain_reg),
    .ext_reset_n_s         (ext_reset_n_s),
    .timeout_cycles        (timeout_cycles),
    .disable_wr            (disable_wr),
    .disable_wdata         (disable_wdata),
    .chip_reset            (chip_reset),
    .test_port_disable_bit (test_port_disable_bit)
  );

  // Port usable only with the fuse programmed and the disable bit clear
  assign port_on = test_port_enable_fuse & ~test_port_disable_bit;

  // Edge finder works on the second synchroniser stage only
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      tck_d_reg <= 1'b0;
    else
      tck_d_reg <= tck_s;
  end

  assign tck_rise = tck_s & ~tck_d_reg;
  assign tck_fall = ~tck_s & tck_d_reg;

  // TAP controller next state from the sampled mode select
  always @*
  begin
    case (state_reg)
      `JFP_S_TLR:      state_next = tms_s ? `JFP_S_TLR      : `JFP_S_RTI;
      `JFP_S_RTI:      state_next = tms_s ? `JFP_S_SEL_DR   : `JFP_S_RTI;
      `JFP_S_SEL_DR:   state_next = tms_s ? `JFP_S_SEL_IR   : `JFP_S_CAP_DR;
      `JFP_S_CAP_DR:   state_next = tms_s ? `JFP_S_EXIT1_DR : `JFP_S_SHIFT_DR;
      `JFP_S_SHIFT_DR: state_next = tms_s ? `JFP_S_EXIT1_DR : `JFP_S_SHIFT_DR;
      `JFP_S_EXIT1_DR: state_next = tms_s ? `JFP_S_UPD_DR   : `JFP_S_PAUSE_DR;
      `JFP_S_PAUSE_DR: state_next = tms_s ? `JFP_S_EXIT2_DR : `JFP_S_PAUSE_DR;
      `JFP_S_EXIT2_DR: state_next = tms_s ? `JFP_S_UPD_DR   : `JFP_S_SHIFT_DR;
      `JFP_S_UPD_DR:   state_next = tms_s ? `JFP_S_SEL_DR   : `JFP_S_RTI;
      `JFP_S_SEL_IR:   state_next = tms_s ? `JFP_S_TLR      : `JFP_S_CAP_IR;
      `JFP_S_CAP_IR:   state_next = tms_s ? `JFP_S_EXIT1_IR : `JFP_S_SHIFT_IR;
      `JFP_S_SHIFT_IR: state_next = tms_s ? `JFP_S_EXIT1_IR : `JFP_S_SHIFT_IR;
      `JFP_S_EXIT1_IR: state_next = tms_s ? `JFP_S_UPD_IR   : `JFP_S_PAUSE_IR;
      `JFP_S_PAUSE_IR: state_next = tms_s ? `JFP_S_EXIT2_IR : `JFP_S_PAUSE_IR;
      `JFP_S_EXIT2_IR: state_next = tms_s ? `JFP_S_UPD_IR   : `JFP_S_SHIFT_IR;
      `JFP_S_UPD_IR:   state_next = tms_s ? `JFP_S_SEL_DR   : `JFP_S_RTI;
      default:         state_next = `JFP_S_TLR;
    endcase
  end

  // Controller is held in Test-Logic-Reset while the port is off; the reset
  // instruction never touches it, only the pins and rst do
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= `JFP_S_TLR;
    else if (!port_on)
      state_reg <= `JFP_S_TLR;
    else if (tck_rise)
      state_reg <= state_next;
  end

  // Instruction register: capture, shift lsb first, update
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ir_reg    <= `JFP_IR_DEFAULT;
      ir_sr_reg <= {`JFP_IR_W{1'b0}};
    end
    else if (state_reg == `JFP_S_TLR)
      ir_reg <= `JFP_IR_DEFAULT;
    else if (tck_rise)
    begin
      case (state_reg)
        `JFP_S_CAP_IR:   ir_sr_reg <= `JFP_IR_CAPTURE;
        `JFP_S_SHIFT_IR: ir_sr_reg <= {tdi_s, ir_sr_reg[`JFP_IR_W-1:1]};
        `JFP_S_UPD_IR:   ir_reg    <= ir_sr_reg;
        default:         ir_sr_reg <= ir_sr_reg;
      endcase
    end
  end

  // Reset chain and bypass bit; the chain keeps its value when the TAP resets
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rst_chain_reg <= 1'b0;
      bypass_reg    <= 1'b0;
    end
    else if (tck_rise && state_reg == `JFP_S_SHIFT_DR)
    begin
      if (is_op(ir_reg, `JFP_OP_RESET))
        rst_chain_reg <= tdi_s;
      bypass_reg <= tdi_s;
    end
  end

  // Key register: power-on clear, lsb-first shift, compare on update
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      key_sr_reg   <= {`JFP_KEY_W{1'b0}};
      unlocked_reg <= 1'b0;
    end
    else if (tck_rise && is_op(ir_reg, `JFP_OP_UNLOCK))
    begin
      if (state_reg == `JFP_S_SHIFT_DR)
        key_sr_reg <= {tdi_s, key_sr_reg[`JFP_KEY_W-1:1]};
      else if (state_reg == `JFP_S_UPD_DR)
        unlocked_reg <= (key_sr_reg == `JFP_KEY);
    end
  end

  assign prog_mode = unlocked_reg;

  // Command register; its low byte doubles as the byte register for 0x6/0x7
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_sr_reg <= {`JFP_CMD_W{1'b0}};
    else if (tck_rise && unlocked_reg)
    begin
      if (is_op(ir_reg, `JFP_OP_COMMAND))
      begin
        if (state_reg == `JFP_S_CAP_DR)
          cmd_sr_reg <= flash_result;
        else if (state_reg == `JFP_S_SHIFT_DR)
          cmd_sr_reg <= {tdi_s, cmd_sr_reg[`JFP_CMD_W-1:1]};
      end
      else if (is_op(ir_reg, `JFP_OP_PAGELOAD) || is_op(ir_reg, `JFP_OP_PAGEREAD))
      begin
        if (state_reg == `JFP_S_CAP_DR && is_op(ir_reg, `JFP_OP_PAGEREAD))
          cmd_sr_reg[7:0] <= read_hi_reg ? flash_word[15:8] : flash_word[7:0];
        else if (state_reg == `JFP_S_SHIFT_DR)
          cmd_sr_reg[7:0] <= {tdi_s, cmd_sr_reg[7:1]};
      end
    end
  end

  // Command apply on Update-DR and one execute clock per tck spent in Run-Test/Idle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flash_cmd_reg      <= {`JFP_CMD_W{1'b0}};
      flash_cmd_load_reg <= 1'b0;
      flash_exec_reg     <= 1'b0;
    end
    else
    begin
      flash_cmd_load_reg <= 1'b0;
      flash_exec_reg     <= 1'b0;
      if (tck_rise && unlocked_reg && is_op(ir_reg, `JFP_OP_COMMAND))
      begin
        if (state_reg == `JFP_S_UPD_DR)
        begin
          flash_cmd_reg      <= cmd_sr_reg;
          flash_cmd_load_reg <= 1'b1;
        end
        else if (state_reg == `JFP_S_RTI)
          flash_exec_reg <= 1'b1;
      end
    end
  end

  // Page load and page read sequencing; toggles restart when the
  // instruction is updated, so a new opcode always begins on the low byte
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hold_reg       <= 8'h00;
      hold_pend_reg  <= 1'b0;
      load_hi_reg    <= 1'b0;
      load_first_reg <= 1'b1;
      read_hi_reg    <= 1'b0;
      pbuf_wr_reg    <= 1'b0;
      pbuf_hi_reg    <= 1'b0;
      pbuf_data_reg  <= 8'h00;
      pc_inc_reg     <= 1'b0;
    end
    else
    begin
      pbuf_wr_reg   <= 1'b0;
      pc_inc_reg    <= 1'b0;
      hold_pend_reg <= 1'b0;
      // Buffer write follows the copy by one chip clock, far inside 11 TCK
      if (hold_pend_reg)
      begin
        pbuf_wr_reg   <= 1'b1;
        pbuf_hi_reg   <= load_hi_reg;
        pbuf_data_reg <= hold_reg;
        load_hi_reg   <= ~load_hi_reg;
      end
      if (tck_rise && state_reg == `JFP_S_UPD_IR)
      begin
        load_hi_reg    <= 1'b0;
        load_first_reg <= 1'b1;
        read_hi_reg    <= 1'b0;
      end
      else if (tck_rise && unlocked_reg && state_reg == `JFP_S_UPD_DR &&
               is_op(ir_reg, `JFP_OP_PAGELOAD))
      begin
        hold_reg       <= cmd_sr_reg[7:0];
        hold_pend_reg  <= 1'b1;
        load_first_reg <= 1'b0;
        if (!load_hi_reg && !load_first_reg)
          pc_inc_reg <= 1'b1;
      end
      else if (tck_rise && unlocked_reg && state_reg == `JFP_S_CAP_DR &&
               is_op(ir_reg, `JFP_OP_PAGEREAD))
      begin
        read_hi_reg <= ~read_hi_reg;
        if (read_hi_reg)
          pc_inc_reg <= 1'b1;
      end
    end
  end

  // Output bit changes on the falling test clock, lsb of the selected path
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      tdo_reg <= 1'b0;
    else if (tck_fall)
    begin
      if (state_reg == `JFP_S_SHIFT_IR)
        tdo_reg <= ir_sr_reg[0];
      else if (state_reg == `JFP_S_SHIFT_DR)
      begin
        case (ir_reg)
          `JFP_OP_RESET:    tdo_reg <= rst_chain_reg;
          `JFP_OP_UNLOCK:   tdo_reg <= key_sr_reg[0];
          `JFP_OP_COMMAND:  tdo_reg <= cmd_sr_reg[0];
          `JFP_OP_PAGELOAD: tdo_reg <= cmd_sr_reg[0];
          `JFP_OP_PAGEREAD: tdo_reg <= cmd_sr_reg[0];
          default:          tdo_reg <= bypass_reg;
        endcase
      end
    end
  end

  // Driven only while shifting, as a tri-state test output should be
  assign tdo_oe = port_on &&
                  (state_reg == `JFP_S_SHIFT_DR || state_reg == `JFP_S_SHIFT_IR);
  assign tdo    = tdo_reg;

  assign flash_cmd      = flash_cmd_reg;
  assign flash_cmd_load = flash_cmd_load_reg;
  assign flash_exec     = flash_exec_reg;
  assign pbuf_wr        = pbuf_wr_reg;
  assign pbuf_hi        = pbuf_hi_reg;
  assign pbuf_data      = pbuf_data_reg;
  assign pc_inc         = pc_inc_reg;

endmodule

// ---- jfp_consts.vh ----
// Constants for the test-port flash programming front end: opcodes, TAP state
// codes, register widths, key and timing counts. Definitions only.
// Assumes it is included by bare name from every design file that needs it.
// How it works
// - Port works only with enable fuse programmed and disable bit clear.
// - Disable bit set and external reset low: bit clears two chip clocks later; here four after the pin, two spent in the synchroniser.
// - All shift registers shift least significant bit first, in and out.
// - Instruction register is four bits, sixteen possible opcodes.
// - Run-Test/Idle makes internal clocks and also serves as an idle state.
// - Opcode 0xc selects one-bit reset register; TAP controller is never reset by it.
// - A one in the reset register holds chip reset at once, unlatched.
// - After the reset register clears, reset stays for the fuse-chosen time-out.
// - Opcode 0x4 selects the sixteen-bit key register shifted in Shift-DR.
// - On Update-DR the key is compared; exact match enters programming mode.
// - Key register clears on power-on reset; programmer clears it on leaving.
// - Opcode 0x5 selects the fifteen-bit command register.
// - Capture-DR loads prior command result; Shift-DR sends it out, new command in.
// - Update-DR applies command to flash; each tck spent in Run-Test/Idle gives one clock.
// - Opcode 0x6 selects eight-bit byte register, low bits of command register.
// - Page load Update-DR copies byte to holding register, writes buffer quickly.
// - Page load updates alternate low then high, starting low after opcode.
// - Page load increments counter before each low write except the first.
// - Opcode 0x7 captures flash bytes, alternating low then high, starting low.
// - Page read increments counter after every high-byte capture, first included.
`ifndef JFP_CONSTS_VH
`define JFP_CONSTS_VH

`define JFP_IR_W          4
`define JFP_IR_CAPTURE    4'h1
`define JFP_IR_DEFAULT    4'hf
`define JFP_OP_RESET      4'hc
`define JFP_OP_UNLOCK     4'h4
`define JFP_OP_COMMAND    4'h5
`define JFP_OP_PAGELOAD   4'h6
`define JFP_OP_PAGEREAD   4'h7
`define JFP_KEY_W         16
`define JFP_KEY           16'ha370
`define JFP_CMD_W         15
`define JFP_BYTE_W        8
`define JFP_DIS_CLR_CYC   2
`define JFP_CNT_W         20

`define JFP_S_TLR         4'h0
`define JFP_S_RTI         4'h1
`define JFP_S_SEL_DR      4'h2
`define JFP_S_CAP_DR      4'h3
`define JFP_S_SHIFT_DR    4'h4
`define JFP_S_EXIT1_DR    4'h5
`define JFP_S_PAUSE_DR    4'h6
`define JFP_S_EXIT2_DR    4'h7
`define JFP_S_UPD_DR      4'h8
`define JFP_S_SEL_IR      4'h9
`define JFP_S_CAP_IR      4'ha
`define JFP_S_SHIFT_IR    4'hb
`define JFP_S_EXIT1_IR    4'hc
`define JFP_S_PAUSE_IR    4'hd
`define JFP_S_EXIT2_IR    4'he
`define JFP_S_UPD_IR      4'hf

`endif

// ---- jfp_sync.v ----
// Two-flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level or clock; no word coherence is implied.
`timescale 1ns/100ps
module jfp_sync
#(
  parameter W = 1
)
(
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

// ---- jfp_rst_ctl.v ----
// Chip reset generation and test-port disable bit for the programming port.
// Assumes ext_reset_n_s is already synchronised and timeout comes from fuses.
`timescale 1ns/100ps
`include "jfp_consts.vh"
module jfp_rst_ctl
(
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  reset_chain,
  input  wire                  ext_reset_n_s,
  input  wire [`JFP_CNT_W-1:0] timeout_cycles,
  input  wire                  disable_wr,
  input  wire                  disable_wdata,
  output wire                  chip_reset,
  output wire                  test_port_disable_bit
);

  reg [`JFP_CNT_W-1:0] tmo_reg;
  reg [1:0]            dis_cnt_reg;
  reg                  dis_reg;
  wire                 reset_cause;

  // Chain output is used unlatched so reset follows it at once
  assign reset_cause = reset_chain | ~ext_reset_n_s;
  assign chip_reset  = reset_cause | (tmo_reg != {`JFP_CNT_W{1'b0}});

  // Time-out restarts while any cause is present and runs down after it
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      tmo_reg <= {`JFP_CNT_W{1'b0}};
    else if (reset_cause)
      tmo_reg <= timeout_cycles;
    else if (tmo_reg != {`JFP_CNT_W{1'b0}})
      tmo_reg <= tmo_reg - 1'b1;
  end

  // External reset low clears a set disable bit after two chip clocks
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dis_reg     <= 1'b0;
      dis_cnt_reg <= 2'h0;
    end
    else if (dis_reg && !ext_reset_n_s)
    begin
      if (dis_cnt_reg == 2'h1)
      begin
        dis_reg     <= 1'b0;
        dis_cnt_reg <= 2'h0;
      end
      else
        dis_cnt_reg <= dis_cnt_reg + 2'h1;
    end
    else
    begin
      dis_cnt_reg <= 2'h0;
      if (disable_wr)
        dis_reg <= disable_wdata;
    end
  end

  assign test_port_disable_bit = dis_reg;

endmodule

// ---- jfp_port_asserts.sv ----
// Concurrent checks on the pins of the flash programming test port.
// Assumes a reset time-out of ten cycles and tck edges well apart.
`timescale 1ns/100ps
module jfp_port_asserts
(
  input wire        clk,
  input wire        rst,
  input wire        tck,
  input wire        tms,
  input wire        tdi,
  input wire        tdo,
  input wire        tdo_oe,
  input wire        ext_reset_n,
  input wire        test_port_enable_fuse,
  input wire [19:0] timeout_cycles,
  input wire        disable_wr,
  input wire        disable_wdata,
  input wire        test_port_disable_bit,
  input wire        chip_reset,
  input wire        prog_mode,
  input wire [14:0] flash_cmd,
  input wire        flash_cmd_load,
  input wire        flash_exec,
  input wire [14:0] flash_result,
  input wire        pbuf_wr,
  input wire        pbuf_hi,
  input wire [7:0]  pbuf_data,
  input wire        pc_inc,
  input wire [15:0] flash_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Pin low long enough to cross the synchroniser
  sequence s_pin_low;
    !ext_reset_n [*3];
  endsequence

  // Bit survives the first clock, then clears within a few
  sequence s_dis_clears;
    test_port_disable_bit ##[1:5] !test_port_disable_bit;
  endsequence

  chk_oe_gated:
    assert property (tdo_oe |-> test_port_enable_fuse && !test_port_disable_bit)
    else $error("tdo driven while port disabled");
  chk_dis_clear:
    assert property ($fell(ext_reset_n) && test_port_disable_bit |=> s_dis_clears)
    else $error("disable bit not cleared by reset pin");
  chk_pin_reset:
    assert property (s_pin_low |-> chip_reset)
    else $error("chip reset missing while pin low");
  chk_reset_hold:
    assert property ($rose(ext_reset_n) && timeout_cycles == 20'h0000a |-> chip_reset [*8])
    else $error("chip reset released before time-out");
  chk_locked_quiet:
    assert property ((pbuf_wr || flash_cmd_load || flash_exec || pc_inc) |-> prog_mode)
    else $error("flash pulse outside programming mode");
  chk_wr_single:
    assert property (pbuf_wr |=> !pbuf_wr [*6])
    else $error("page buffer written twice for one update");
  chk_pcinc_low:
    assert property (pbuf_wr && $past(pc_inc) |-> !pbuf_hi)
    else $error("counter stepped before a high byte");
  chk_exec_single:
    assert property (flash_exec |=> !flash_exec [*6])
    else $error("more than one execute clock per idle tck");
  chk_tdo_at_fall:
    assert property ($changed(tdo) |-> !$past(tck, 2))
    else $error("tdo changed while tck high");
endmodule

// ---- jfp_prog_model.sv ----
// Behavioural test-port programmer: drives tck, tms, tdi and samples tdo.
// Assumes scans start from Run-Test/Idle; tck rests low between frames.
`timescale 1ns/100ps
module jfp_prog_model
(
  output reg  tck,
  output reg  tms,
  output reg  tdi,
  input  wire tdo
);
  // An 8 MHz test clock stays far below the chip clock
  initial
  begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
  end

  // One tck period; tdo is taken at the rising edge
  task step(input logic m, input logic b, output logic q);
  begin
    #1;
    tms = m;
    tdi = b;
    #61.5;
    tck = 1'b1;
    q = tdo;
    #62.5;
    tck = 1'b0;
  end
  endtask

  // Idle cycles; tdi toggles since nothing listens to it
  task idle(input int n);
    logic q;
  begin
    repeat (n) step(1'b0, ~tdi, q);
  end
  endtask

  task reset_tap;
    logic q;
  begin
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  end
  endtask

  // Full IR or DR scan from idle back to idle, least significant bit first
  task scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout);
    logic q;
    int   i;
  begin
    dout = 16'h0000;
    step(1'b1, ~tdi, q);
    if (ir)
      step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  end
  endtask
endmodule

// ---- jfp_port_tb_top.sv ----
// Self-checking bench for the test-port flash programming front end.
// Assumes the programmer model owns the link; flash side is plain stimulus.
`timescale 1ns/100ps
module jfp_port_tb_top;
  logic        clk, rst, tck, tms, tdi, tdo, tdo_oe, ext_reset_n, fuse, oe_seen, pc_prev;
  logic        disable_wr, disable_wdata, test_port_disable_bit, chip_reset, prog_mode;
  logic        flash_cmd_load, flash_exec, pbuf_wr, pbuf_hi, pc_inc;
  logic [19:0] timeout_cycles;
  logic [14:0] flash_cmd, flash_result;
  logic [7:0]  pbuf_data;
  logic [15:0] flash_word, d;
  logic [9:0]  wr_log[$];
  int          n_mismatch = 0, comparisons = 0, n_pc = 0, n_exec = 0, cycles = 0, n_load = 0;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  jfp_port jfp_port_inst (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .ext_reset_n(ext_reset_n), .test_port_enable_fuse(fuse),
    .timeout_cycles(timeout_cycles), .disable_wr(disable_wr), .disable_wdata(disable_wdata),
    .test_port_disable_bit(test_port_disable_bit), .chip_reset(chip_reset),
    .prog_mode(prog_mode), .flash_cmd(flash_cmd), .flash_cmd_load(flash_cmd_load),
    .flash_exec(flash_exec), .flash_result(flash_result), .pbuf_wr(pbuf_wr),
    .pbuf_hi(pbuf_hi), .pbuf_data(pbuf_data), .pc_inc(pc_inc), .flash_word(flash_word));
  // Released tdo line floats high through its pull-up
  jfp_prog_model prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo : 1'b1));

  // Record flash-side pulses; the cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (pbuf_wr === 1'b1)
      wr_log.push_back({pc_prev, pbuf_hi, pbuf_data});
    pc_prev = pc_inc; // Counter step comes the cycle before its write
    if (flash_cmd_load === 1'b1)
      n_load = n_load + 1;
    if (pc_inc === 1'b1)
      n_pc = n_pc + 1;
    if (flash_exec === 1'b1)
      n_exec = n_exec + 1;
    if (tdo_oe === 1'b1)
      oe_seen = 1'b1;
    if (cycles == 40000)
    begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end

  task tick(input int n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      n_mismatch = n_mismatch + 1;
    end
  end
  endtask

  // Disabled port stays silent until the reset pin frees it
  task test_disable;
    int n;
  begin
    disable_wr = 1'b1;
    disable_wdata = 1'b1;
    tick(1);
    disable_wr = 1'b0;
    tick(2);
    oe_seen = 1'b0;
    prog.scan(1'b1, 4, 16'h000c, d);
    chk("tdo_oe_off", 16'h0000, {15'h0, oe_seen});
    ext_reset_n = 1'b0;
    tick(2);
    chk("dis_bit_early", 16'h0001, {15'h0, test_port_disable_bit});
    tick(4);
    chk("dis_bit_clear", 16'h0000, {15'h0, test_port_disable_bit});
    ext_reset_n = 1'b1;
    n = 0;
    while (chip_reset === 1'b1 && n < 40)
    begin
      tick(1);
      n = n + 1;
    end
    chk("reset_timeout", 16'h0001, {15'h0, n >= 10 && n <= 14});
  end
  endtask

  // Reset register holds the chip; the TAP keeps working meanwhile
  task test_reset_reg;
  begin
    prog.reset_tap();
    oe_seen = 1'b0;
    prog.scan(1'b1, 4, 16'h000c, d);
    chk("ir_capture", 16'h0001, d);
    chk("tdo_oe_on", 16'h0001, {15'h0, oe_seen});
    prog.scan(1'b0, 1, 16'h0001, d);
    prog.idle(4);
    chk("chip_reset_on", 16'h0001, {15'h0, chip_reset});
    prog.scan(1'b1, 4, 16'h000c, d);
    chk("ir_kept", 16'h0001, d);
    prog.scan(1'b0, 1, 16'h0000, d);
    chk("reset_bit_out", 16'h0001, d);
    chk("chip_reset_off", 16'h0000, {15'h0, chip_reset});
  end
  endtask

  // Page load refused while locked; a wrong key leaves it locked
  task test_unlock;
  begin
    wr_log.delete();
    prog.scan(1'b1, 4, 16'h0006, d);
    prog.scan(1'b0, 8, 16'h00a5, d);
    chk("locked_writes", 16'h0000, 16'(wr_log.size()));
    prog.scan(1'b1, 4, 16'h0004, d);
    prog.scan(1'b0, 16, 16'ha371, d);
    chk("mode_bad_key", 16'h0000, {15'h0, prog_mode});
    prog.scan(1'b0, 16, 16'ha370, d);
    chk("mode_good_key", 16'h0001, {15'h0, prog_mode});
  end
  endtask

  task test_command;
  begin
    flash_result = 15'h2a5b;
    prog.scan(1'b1, 4, 16'h0005, d);
    n_load = 0;
    prog.scan(1'b0, 15, 16'h1234, d);
    chk("cmd_loads", 16'h0001, 16'(n_load));
    chk("cmd_result", 16'h2a5b, d);
    chk("flash_cmd", 16'h1234, {1'b0, flash_cmd});
    n_exec = 0;
    prog.idle(3);
    chk("exec_pulses", 16'h0003, 16'(n_exec));
  end
  endtask

  // Four bytes: low, high, low with counter step, high
  task test_page_load;
    int i;
  begin
    prog.scan(1'b1, 4, 16'h0006, d);
    wr_log.delete();
    for (i = 0; i < 4; i++)
      prog.scan(1'b0, 8, {8'h00, 8'h3c + i[7:0]}, d);
    chk("page_writes", 16'h0004, 16'(wr_log.size()));
    for (i = 0; i < 4; i++)
      chk("page_entry", {6'h00, i == 2, i[0], 8'h3c + i[7:0]}, {6'h00, wr_log[i]});
  end
  endtask

  task test_page_read;
  begin
    flash_word = 16'hc35a;
    prog.scan(1'b1, 4, 16'h0007, d);
    n_pc = 0;
    prog.scan(1'b0, 8, 16'h0000, d);
    chk("read_low", 16'h005a, d);
    chk("pc_after_low", 16'h0000, 16'(n_pc));
    prog.scan(1'b0, 8, 16'h0000, d);
    chk("read_high", 16'h00c3, d);
    chk("pc_after_high", 16'h0001, 16'(n_pc));
  end
  endtask

  // Clearing the key leaves programming mode and locks page loads again
  task test_leave;
  begin
    prog.scan(1'b1, 4, 16'h0004, d);
    prog.scan(1'b0, 16, 16'h0000, d);
    chk("mode_left", 16'h0000, {15'h0, prog_mode});
    wr_log.delete();
    prog.scan(1'b1, 4, 16'h0006, d);
    prog.scan(1'b0, 8, 16'h0055, d);
    chk("relocked_writes", 16'h0000, 16'(wr_log.size()));
    tick(1);
    fuse = 1'b0;
    oe_seen = 1'b0;
    prog.scan(1'b1, 4, 16'h0006, d);
    chk("tdo_fuse_off", 16'h000f, d);
    chk("oe_fuse_off", 16'h0000, {15'h0, oe_seen});
  end
  endtask

  task give_verdict;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  // Short reset time-out keeps the run brief
  initial
  begin
    rst = 1'b1;
    fuse = 1'b1;
    ext_reset_n = 1'b1;
    timeout_cycles = 20'h0000a;
    disable_wr = 1'b0;
    disable_wdata = 1'b0;
    flash_result = 15'h0000;
    flash_word = 16'h0000;
    oe_seen = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(6);
    test_disable();
    test_reset_reg();
    test_unlock();
    test_command();
    test_page_load();
    test_page_read();
    test_leave();
    give_verdict();
  end
endmodule

bind jfp_port jfp_port_asserts jfp_port_asserts_inst (.clk(clk), .rst(rst), .tck(tck),
  .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ext_reset_n(ext_reset_n),
  .test_port_enable_fuse(test_port_enable_fuse), .timeout_cycles(timeout_cycles),
  .disable_wr(disable_wr), .disable_wdata(disable_wdata),
  .test_port_disable_bit(test_port_disable_bit), .chip_reset(chip_reset),
  .prog_mode(prog_mode), .flash_cmd(flash_cmd), .flash_cmd_load(flash_cmd_load),
  .flash_exec(flash_exec), .flash_result(flash_result), .pbuf_wr(pbuf_wr),
  .pbuf_hi(pbuf_hi), .pbuf_data(pbuf_data), .pc_inc(pc_inc), .flash_word(flash_word));
